/* design/sync_pulse_output_control.sv */
// Sync pulse output control: activation, start check, pulse shaping, status and acknowledge
//
// Function
// - Scheduled pulses run only while activation bit0 set; bit7 debug pulse does not need it
// - First output pulses only when bit1 set
// - Second output pulses only when bit2 set
// - Bit3 sets bit0 after start time write
// - Bit4 extends 32-bit start time to 64
// - Bit5 fires immediately when start outside window
// - Bit6 picks near window 2^31 or half
// - Bit7 emits one debug pulse, reads zero
// - Pulse held programmed length in 10ns steps
// - Length zero holds pulse until status read
// - Length read-only, reset 0, loaded from config
// - Status bits 0,1 show first and second pulse pending
// - Status bit2 holds activation plausibility result
// - First status register shows pending in bit0
// - Host write acknowledge clears event request bit2
// - Without write acknowledge host read clears request
// - Second status register, clears event request bit3
// - Unit-control bit chooses which side writes
// - Cycle time zero gives single first pulse
`default_nettype none
module sync_pulse_output_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register ports
  input wire sync_pulse_pkg::reg_access_t netAccess,
  output sync_pulse_pkg::reg_reply_t netReply,
  input wire sync_pulse_pkg::reg_access_t hostAccess,
  output sync_pulse_pkg::reg_reply_t hostReply,
  // Configuration
  input wire logic unitCtrlHost,
  input wire logic writeAckEnable,
  input wire logic lenLoad,
  input wire logic [15:0] lenLoadValue,
  output logic [15:0] cfgWordAddr,
  // Distributed time
  input wire logic [63:0] systemTime,
  input wire sync_pulse_pkg::start_write_t startWrite,
  input wire logic [31:0] cycleTime0,
  input wire logic [31:0] cycleTime1,
  // Outputs
  output logic firstSyncOutput,
  output logic secondSyncOutput,
  output logic eventReq2,
  output logic eventReq3
);
  import sync_pulse_pkg::*;
  function automatic logic [19:0] lenCycles(input logic [15:0] len);
    logic [31:0] n;
    n = (32'(len) * 32'(PULSE_UNIT_NS) + 32'(CLK_PERIOD_NS) - 32'd1) / 32'(CLK_PERIOD_NS);
    if (n == 32'd0) begin
      n = 32'd1;
    end
    return n[19:0];
  endfunction : lenCycles
  function automatic logic reached(input logic [63:0] now, input logic [63:0] t);
    logic [63:0] diff;
    diff = now - t;
    return ~diff[63];
  endfunction : reached
  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  logic [7:0] act_q;
  logic [15:0] len_q;
  logic pend0_q;
  logic pend1_q;
  logic outside_q;
  logic netWrAct;
  logic hostWrAct;
  logic actWr;
  logic [7:0] actWdata;
  logic readS0;
  logic readS1;
  logic hostAck0;
  logic hostAck1;
  // Only the side that owns the unit may write activation
  assign netWrAct = netAccess.req && netAccess.wr && netAccess.addr == ADDR_ACT && !unitCtrlHost;
  assign hostWrAct = hostAccess.req && hostAccess.wr && hostAccess.addr == ADDR_ACT && unitCtrlHost;
  assign actWr = netWrAct || hostWrAct;
  assign actWdata = hostWrAct ? hostAccess.wdata : netAccess.wdata;
  assign readS0 = (netAccess.req && !netAccess.wr && netAccess.addr == ADDR_S0)
      || (hostAccess.req && !hostAccess.wr && hostAccess.addr == ADDR_S0);
  assign readS1 = (netAccess.req && !netAccess.wr && netAccess.addr == ADDR_S1)
      || (hostAccess.req && !hostAccess.wr && hostAccess.addr == ADDR_S1);
  // Value written for acknowledge is ignored
  assign hostAck0 = hostAccess.req && hostAccess.addr == ADDR_S0 && (hostAccess.wr == writeAckEnable);
  assign hostAck1 = hostAccess.req && hostAccess.addr == ADDR_S1 && (hostAccess.wr == writeAckEnable);
  function automatic logic [7:0] readByte(input logic [15:0] a, input logic [7:0] act,
      input logic [15:0] len, input logic p0, input logic p1, input logic o);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      ADDR_ACT: r = {1'b0, act[6:0]};
      ADDR_LEN_LO: r = len[7:0];
      ADDR_LEN_HI: r = len[15:8];
      ADDR_STAT: r = {5'h00, o, p1, p0};
      ADDR_S0: r = {7'h00, p0};
      ADDR_S1: r = {7'h00, p1};
      default: r = 8'h00;
    endcase
    return r;
  endfunction : readByte
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      netReply <= '0;
      hostReply <= '0;
    end else begin
      netReply.valid <= netAccess.req;
      netReply.rdata <= netAccess.req && !netAccess.wr
          ? readByte(netAccess.addr, act_q, len_q, pend0_q, pend1_q, outside_q) : 8'h00;
      hostReply.valid <= hostAccess.req;
      hostReply.rdata <= hostAccess.req && !hostAccess.wr
          ? readByte(hostAccess.addr, act_q, len_q, pend0_q, pend1_q, outside_q) : 8'h00;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Activation register and pulse length
  logic dbgFire_q;
  logic activate;
  logic done0_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      act_q <= ACT_RESET;
      dbgFire_q <= 1'b0;
    end else begin
      dbgFire_q <= actWr && actWdata[ACT_DBG];
      if (actWr) begin
        act_q <= {1'b0, actWdata[6:0]};
      end else if (startWrite.done && act_q[ACT_AUTO]) begin
        act_q[ACT_UNIT] <= 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      len_q <= LEN_RESET;
      cfgWordAddr <= LEN_CFG_WORD;
    end else begin
      cfgWordAddr <= LEN_CFG_WORD;
      if (lenLoad) begin
        len_q <= lenLoadValue;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Start time capture and plausibility
  logic [63:0] start_q;
  logic [63:0] startExt;
  logic [63:0] startDiff;
  logic [63:0] nearWin;
  logic unitOn_q;
  logic [63:0] next0_q;
  logic [63:0] next1_q;
  logic armed1_q;
  logic fire0;
  logic fire1;
  logic immediate_q;
  always_comb begin
    startExt = startWrite.value;
    if (startWrite.lowOnly && act_q[ACT_EXT]) begin
      // Pick the upper word that puts the start at or after now
      startExt[63:32] = systemTime[63:32];
      if (startWrite.value[31:0] < systemTime[31:0]) begin
        startExt[63:32] = systemTime[63:32] + 32'd1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      start_q <= '0;
    end else if (startWrite.done) begin
      start_q <= startExt;
    end
  end
  assign nearWin = act_q[ACT_NEAR] ? NEAR_SHORT : NEAR_HALF;
  assign startDiff = start_q - systemTime;
  assign activate = act_q[ACT_UNIT] && !unitOn_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      unitOn_q <= 1'b0;
      outside_q <= 1'b0;
      immediate_q <= 1'b0;
    end else begin
      unitOn_q <= act_q[ACT_UNIT];
      immediate_q <= 1'b0;
      if (activate) begin
        outside_q <= startDiff >= nearWin;
        immediate_q <= act_q[ACT_PLAUS] && startDiff >= nearWin;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Pulse scheduling
  assign fire0 = unitOn_q && act_q[ACT_UNIT] && act_q[ACT_EN0] && !done0_q
      && (immediate_q || reached(systemTime, next0_q));
  assign fire1 = unitOn_q && act_q[ACT_UNIT] && act_q[ACT_EN1] && armed1_q
      && reached(systemTime, next1_q);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      next0_q <= '0;
      next1_q <= '0;
      done0_q <= 1'b0;
      armed1_q <= 1'b0;
    end else if (activate) begin
      next0_q <= start_q;
      done0_q <= 1'b0;
      armed1_q <= 1'b0;
    end else begin
      if (fire0) begin
        next0_q <= systemTime + 64'(cycleTime0);
        done0_q <= cycleTime0 == 32'h0000_0000;
        next1_q <= systemTime + 64'(cycleTime1);
        armed1_q <= 1'b1;
      end else if (fire1) begin
        armed1_q <= 1'b0;
      end
    end
  end
  // Pending flags: set wins over the clear on activation
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pend0_q <= 1'b0;
      pend1_q <= 1'b0;
    end else if (!act_q[ACT_UNIT]) begin
      pend0_q <= 1'b0;
      pend1_q <= 1'b0;
    end else if (activate) begin
      pend0_q <= 1'b1;
      pend1_q <= 1'b1;
    end else begin
      if (fire0) begin
        pend0_q <= 1'b0;
      end
      if (fire1) begin
        pend1_q <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Pulse shaping
  logic [19:0] cnt0_q;
  logic [19:0] cnt1_q;
  logic start0;
  logic start1;
  assign start0 = fire0 || (dbgFire_q && act_q[ACT_EN0]);
  assign start1 = fire1 || (dbgFire_q && act_q[ACT_EN1]);
  // A new pulse restarts the count rather than being dropped
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      firstSyncOutput <= 1'b0;
      cnt0_q <= '0;
    end else if (start0) begin
      firstSyncOutput <= 1'b1;
      cnt0_q <= lenCycles(len_q) - 20'd1;
    end else if (len_q == 16'h0000) begin
      if (readS0) begin
        firstSyncOutput <= 1'b0;
      end
    end else if (cnt0_q != 20'd0) begin
      cnt0_q <= cnt0_q - 20'd1;
    end else begin
      firstSyncOutput <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      secondSyncOutput <= 1'b0;
      cnt1_q <= '0;
    end else if (start1) begin
      secondSyncOutput <= 1'b1;
      cnt1_q <= lenCycles(len_q) - 20'd1;
    end else if (len_q == 16'h0000) begin
      if (readS1) begin
        secondSyncOutput <= 1'b0;
      end
    end else if (cnt1_q != 20'd0) begin
      cnt1_q <= cnt1_q - 20'd1;
    end else begin
      secondSyncOutput <= 1'b0;
    end
  end
  // Event requests: a new pulse wins over an acknowledge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      eventReq2 <= 1'b0;
      eventReq3 <= 1'b0;
    end else begin
      if (start0) begin
        eventReq2 <= 1'b1;
      end else if (hostAck0) begin
        eventReq2 <= 1'b0;
      end
      if (start1) begin
        eventReq3 <= 1'b1;
      end else if (hostAck1) begin
        eventReq3 <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_unit_gate: assert property (!act_q[ACT_UNIT] && !dbgFire_q && !firstSyncOutput |=> !firstSyncOutput)
    else $error("first output pulsed with unit off");
  chk_first_enable: assert property ($rose(firstSyncOutput) |-> $past(act_q[ACT_EN0]))
    else $error("first output pulsed while disabled");
  chk_second_enable: assert property ($rose(secondSyncOutput) |-> $past(act_q[ACT_EN1]))
    else $error("second output pulsed while disabled");
  chk_auto_act: assert property (startWrite.done && act_q[ACT_AUTO] && !actWr |=> act_q[ACT_UNIT])
    else $error("auto activation missing");
  chk_debug_clear: assert property (actWr |=> !act_q[ACT_DBG])
    else $error("debug bit not self clearing");
  chk_debug_pulse: assert property (dbgFire_q && act_q[ACT_EN0] |=> firstSyncOutput)
    else $error("debug pulse missing");
  chk_pulse_len: assert property (start0 && len_q != 16'h0000 && len_q <= 16'h000a ##1 !start0
      |-> firstSyncOutput ##1 (!firstSyncOutput || start0))
    else $error("pulse length wrong");
  chk_ack_hold: assert property (firstSyncOutput && len_q == 16'h0000 && !readS0 && !start0
      |=> firstSyncOutput)
    else $error("acknowledge mode pulse dropped");
  chk_pend_clear: assert property (fire0 && !activate && act_q[ACT_UNIT] |=> !pend0_q)
    else $error("pending not cleared by first pulse");
  chk_ack_clear: assert property (hostAck0 && !start0 |=> !eventReq2)
    else $error("event request not acknowledged");
  chk_single_shot: assert property (fire0 && cycleTime0 == 32'h0000_0000 && !activate
      |=> !fire0 [*2])
    else $error("single shot repeated");
  chk_owner_write: assert property (netAccess.req && netAccess.wr && netAccess.addr == ADDR_ACT
      && unitCtrlHost && !hostWrAct && !startWrite.done |=> $stable(act_q[6:0]))
    else $error("non-owner wrote activation");
  cov_first_pulse: cover property ($rose(firstSyncOutput));
  cov_second_pulse: cover property ($rose(secondSyncOutput));
  cov_immediate: cover property (immediate_q && fire0);
  cov_ack_mode: cover property (firstSyncOutput && len_q == 16'h0000 ##1 !firstSyncOutput);
endmodule : sync_pulse_output_control
`default_nettype wire

/* shared/sync_pulse_pkg.sv */
// Constants and carrier types for the sync pulse output control block
`default_nettype none
package sync_pulse_pkg;
  // Register byte addresses
  localparam logic [15:0] ADDR_ACT = 16'h0981;
  localparam logic [15:0] ADDR_LEN_LO = 16'h0982;
  localparam logic [15:0] ADDR_LEN_HI = 16'h0983;
  localparam logic [15:0] ADDR_STAT = 16'h0984;
  localparam logic [15:0] ADDR_S0 = 16'h098e;
  localparam logic [15:0] ADDR_S1 = 16'h098f;
  // Activation register fields
  localparam int ACT_UNIT = 0;
  localparam int ACT_EN0 = 1;
  localparam int ACT_EN1 = 2;
  localparam int ACT_AUTO = 3;
  localparam int ACT_EXT = 4;
  localparam int ACT_PLAUS = 5;
  localparam int ACT_NEAR = 6;
  localparam int ACT_DBG = 7;
  // Activation status fields
  localparam int STAT_PEND0 = 0;
  localparam int STAT_PEND1 = 1;
  localparam int STAT_OUT = 2;
  // Reset values and configuration word
  localparam logic [7:0] ACT_RESET = 8'h00;
  localparam logic [15:0] LEN_RESET = 16'h0000;
  localparam logic [15:0] LEN_CFG_WORD = 16'h0002;
  // Timing
  localparam int PULSE_UNIT_NS = 10;
  localparam int CLK_PERIOD_NS = 100;
  // Near future windows
  localparam logic [63:0] NEAR_SHORT = 64'h0000_0000_8000_0000;
  localparam logic [63:0] NEAR_HALF = 64'h8000_0000_0000_0000;

  typedef struct packed {
    logic req;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } reg_reply_t;

  typedef struct packed {
    logic done;
    logic lowOnly;
    logic [63:0] value;
  } start_write_t;
endpackage : sync_pulse_pkg
`default_nettype wire

/* verification/sync_pulse_far_model.sv */
// Far-side model: byte accesses on one register port and counting of sync pulses
`default_nettype none
module sync_pulse_far_model (
  // Clock
  input wire logic clk,
  // Register port
  output sync_pulse_pkg::reg_access_t acc,
  input wire sync_pulse_pkg::reg_reply_t rsp,
  // Sync outputs
  input wire logic firstSyncOutput,
  input wire logic secondSyncOutput
);
  timeunit 1ns;
  timeprecision 1ns;
  import sync_pulse_pkg::*;
  int nFirst = 0;
  int nSecond = 0;
  logic first_q = 1'b0;
  logic second_q = 1'b0;
  initial acc = '0;
  // Rising edges only, ack-mode pulses may stand for many cycles
  always @(posedge clk) begin
    nFirst <= nFirst + int'(firstSyncOutput && !first_q);
    nSecond <= nSecond + int'(secondSyncOutput && !second_q);
    first_q <= firstSyncOutput;
    second_q <= secondSyncOutput;
  end
  // Leading edge wait keeps back-to-back calls from driving req twice in one step
  task automatic xfer(input logic wr, input logic [15:0] addr, input logic [7:0] wdata,
      output logic [7:0] rdata, output bit ok);
    int n;
    n = 0;
    @(posedge clk);
    #1 acc = '{1'b1, wr, addr, wdata};
    @(posedge clk);
    #1 acc.req = 1'b0;
    while (rsp.valid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1 n++;
    end
    rdata = rsp.rdata;
    ok = (rsp.valid === 1'b1);
  endtask : xfer
  task automatic ackWrite(input logic [15:0] addr, output bit ok);
    logic [7:0] unused;
    xfer(1'b1, addr, 8'h00, unused, ok);
  endtask : ackWrite
endmodule : sync_pulse_far_model
`default_nettype wire

/* verification/test_sync_pulse_output_control.sv */
// Self-checking bench for the sync pulse output control block
`default_nettype none
module test_sync_pulse_output_control;
  timeunit 1ns;
  timeprecision 1ns;
  import sync_pulse_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  reg_access_t netAccess;
  reg_access_t hostAccess;
  reg_reply_t netReply;
  reg_reply_t hostReply;
  logic unitCtrlHost = 1'b0;
  logic writeAckEnable = 1'b0;
  logic lenLoad = 1'b0;
  logic [15:0] lenLoadValue = 16'h0000;
  logic [15:0] cfgWordAddr;
  logic [63:0] systemTime = 64'h0000_0001_0000_0000;
  start_write_t startWrite = '0;
  logic [31:0] cycleTime0 = 32'h0000_0000;
  logic [31:0] cycleTime1 = 32'h0000_012c;
  logic firstSyncOutput;
  logic secondSyncOutput;
  logic eventReq2;
  logic eventReq3;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [7:0] rd;
  logic [15:0] len;
  logic [63:0] startT;
  int cyc;
  int base;
  int base2;
  bit ok;
  logic [15:0] regs [7] = '{ADDR_ACT, ADDR_LEN_LO, ADDR_LEN_HI, ADDR_STAT, ADDR_S0, ADDR_S1, 16'h0985};

  initial forever #50 clk = ~clk;
  always @(posedge clk) systemTime <= systemTime + 64'h64;

  sync_pulse_output_control uut (.clk(clk), .rst_b(rst_b), .netAccess(netAccess), .netReply(netReply),
    .hostAccess(hostAccess), .hostReply(hostReply), .unitCtrlHost(unitCtrlHost),
    .writeAckEnable(writeAckEnable), .lenLoad(lenLoad), .lenLoadValue(lenLoadValue),
    .cfgWordAddr(cfgWordAddr), .systemTime(systemTime), .startWrite(startWrite), .cycleTime0(cycleTime0),
    .cycleTime1(cycleTime1), .firstSyncOutput(firstSyncOutput), .secondSyncOutput(secondSyncOutput),
    .eventReq2(eventReq2), .eventReq3(eventReq3));
  sync_pulse_far_model netSide (.clk(clk), .acc(netAccess), .rsp(netReply),
    .firstSyncOutput(firstSyncOutput), .secondSyncOutput(secondSyncOutput));
  sync_pulse_far_model host (.clk(clk), .acc(hostAccess), .rsp(hostReply),
    .firstSyncOutput(firstSyncOutput), .secondSyncOutput(secondSyncOutput));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic acc(input bit viaHost, input logic wr, input logic [15:0] a, input logic [7:0] d);
    if (viaHost) host.xfer(wr, a, d, rd, ok);
    else netSide.xfer(wr, a, d, rd, ok);
    if (!ok) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : acc
  task automatic waitHi(input bit second, input int bound);
    cyc = 0;
    while ((second ? secondSyncOutput : firstSyncOutput) !== 1'b1) begin
      @(posedge clk);
      #1 cyc++;
      if (cyc > bound) begin
        n_mismatch++;
        end_of_test();
      end
    end
  endtask : waitHi
  task automatic writeStart(input logic lowOnly, input logic [63:0] v);
    startWrite = '{1'b1, lowOnly, v};
    @(posedge clk);
    #1 startWrite.done = 1'b0;
  endtask : writeStart
  task automatic loadLen(input logic [15:0] v);
    lenLoad = 1'b1;
    lenLoadValue = v;
    @(posedge clk);
    #1 lenLoad = 1'b0;
  endtask : loadLen
  // Reference model: length rounds up to whole clocks, never below one
  function automatic int pulseCycles(int l);
    int c;
    c = (l * PULSE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : pulseCycles
  function automatic bit outsideWin(logic [63:0] s, logic [63:0] now, bit shortWin);
    return (s - now) >= (shortWin ? NEAR_SHORT : NEAR_HALF);
  endfunction : outsideWin

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hf7dc5b80));
    repeat (10) @(posedge clk);
    #1 rst_b = 1'b1;
    foreach (regs[i]) begin
      acc(0, 0, regs[i], 8'h00);
      check(rd, 8'h00);
    end
    check(cfgWordAddr, LEN_CFG_WORD);
    $display("test reset values done");
    for (int o = 0; o < 2; o++) begin
      unitCtrlHost = o[0];
      acc(!o, 1, ADDR_ACT, 8'h02);
      acc(o, 0, ADDR_ACT, 8'h00);
      check(rd, 8'h00);
      acc(o, 1, ADDR_ACT, 8'h02);
      acc(!o, 0, ADDR_ACT, 8'h00);
      check(rd, 8'h02);
      acc(o, 1, ADDR_ACT, 8'h00);
    end
    unitCtrlHost = 1'b0;
    $display("test ownership done");
    len = 16'(1 + $urandom % 40);
    loadLen(len);
    acc(0, 1, ADDR_LEN_LO, 8'hff);
    acc(1, 0, ADDR_LEN_LO, 8'h00);
    check(rd, len[7:0]);
    acc(0, 0, ADDR_LEN_HI, 8'h00);
    check(rd, len[15:8]);
    base = netSide.nSecond;
    acc(0, 1, ADDR_ACT, 8'h86);
    waitHi(0, 6);
    cyc = 0;
    while (firstSyncOutput === 1'b1 && cyc < 100) begin
      @(posedge clk);
      #1 cyc++;
    end
    check(cyc, pulseCycles(len));
    check(netSide.nSecond - base, 1);
    acc(0, 0, ADDR_ACT, 8'h00);
    check(rd, 8'h06);
    for (int en = 0; en < 3; en++) begin
      base = netSide.nFirst;
      base2 = netSide.nSecond;
      acc(0, 1, ADDR_ACT, 8'h80 | 8'(en << 1));
      repeat (8) @(posedge clk);
      #1 check(netSide.nFirst - base, en & 1);
      check(netSide.nSecond - base2, en >> 1);
    end
    $display("test length and debug done");
    acc(0, 1, ADDR_ACT, 8'h06);
    startT = systemTime + 64'd3000;
    writeStart(0, startT);
    acc(0, 0, ADDR_ACT, 8'h00);
    check(rd, 8'h06);
    base = netSide.nFirst;
    acc(0, 1, ADDR_ACT, 8'h07);
    acc(0, 0, ADDR_STAT, 8'h00);
    check(rd, 8'h03);
    acc(1, 0, ADDR_S0, 8'h00);
    check(rd, 8'h01);
    waitHi(0, 40);
    check(systemTime >= startT, 1);
    waitHi(1, 10);
    acc(0, 0, ADDR_STAT, 8'h00);
    check(rd, 8'h00);
    acc(0, 0, ADDR_S1, 8'h00);
    check(rd, 8'h00);
    repeat (40) @(posedge clk);
    #1 check(netSide.nFirst - base, 1);
    $display("test activation done");
    // Short length so the one-cycle pulse check is reached
    loadLen(16'(1 + $urandom % 10));
    for (int w = 0; w < 2; w++) begin
      acc(0, 1, ADDR_ACT, 8'h00);
      startT = systemTime + 64'h1_0000_0000;
      writeStart(0, startT);
      base = netSide.nFirst;
      acc(0, 1, ADDR_ACT, 8'h23 | 8'(w << 6));
      acc(0, 0, ADDR_STAT, 8'h00);
      check(rd[2], outsideWin(startT, systemTime, w));
      repeat (8) @(posedge clk);
      #1 check(netSide.nFirst - base, w);
    end
    for (int e = 0; e < 2; e++) begin
      acc(0, 1, ADDR_ACT, 8'h00);
      acc(0, 1, ADDR_ACT, 8'h6a | 8'(e << 4));
      startT = {systemTime[63:32], systemTime[31:0] + 32'd500000};
      writeStart(1, {32'h0, startT[31:0]});
      acc(0, 0, ADDR_ACT, 8'h00);
      check(rd, 8'h6b | 8'(e << 4));
      acc(0, 0, ADDR_STAT, 8'h00);
      check(rd[2], outsideWin(e ? startT : {32'h0, startT[31:0]}, systemTime, 1));
    end
    $display("test plausibility done");
    acc(0, 1, ADDR_ACT, 8'h00);
    loadLen(16'h0000);
    writeAckEnable = 1'b1;
    acc(0, 1, ADDR_ACT, 8'h86);
    waitHi(1, 6);
    check({eventReq2, eventReq3}, 2'b11);
    host.ackWrite(ADDR_S0, ok);
    check(ok, 1'b1);
    repeat (2) @(posedge clk);
    #1 check({eventReq2, firstSyncOutput}, 2'b01);
    acc(0, 0, ADDR_S0, 8'h00);
    repeat (2) @(posedge clk);
    #1 check(firstSyncOutput, 1'b0);
    writeAckEnable = 1'b0;
    acc(1, 1, ADDR_S1, 8'h00);
    repeat (2) @(posedge clk);
    #1 check(eventReq3, 1'b1);
    acc(1, 0, ADDR_S1, 8'h00);
    repeat (2) @(posedge clk);
    #1 check({eventReq3, secondSyncOutput}, 2'b00);
    $display("test acknowledge done");
    end_of_test();
  end
endmodule : test_sync_pulse_output_control
`default_nettype wire
